/* flash_seq_pkg.sv */
// Purpose: shared constants and types for the flash command sequencer
// Assumes: 40 MHz system clock, host serial clock independent of it
// Notes: times in ns, cycle counts derive from them
//
// Summary of operation
// - secure erase 44H needs latch, opcode-only frame
// - secure erase runs timed cycle, latch cleared
// - lock bit set ignores secure erase
// - three independent 256-byte secure regions
// - region address decode, zero fields, offset
// - secure program 42H, address, 1-256 bytes
// - secure program runs timed cycle, latch cleared
// - locked region ignores secure program
// - reset needs 66h then 99h directly
// - accepted reset aborts work, clears volatile state
// - about 30us recovery, only read commands taken
// - parameter read 5AH returns parameter tables
// - page program 02H, latch, address, data
// - data wraps within the current page
// - over 256 bytes keeps last 256
// - fewer bytes leave other page bytes unchanged
// - select must rise on byte boundary
// - page program timed cycle, flag, latch cleared
// - protected pages are never programmed
// - four-line program needs enable bit, latch
// - secure read offset wraps FFH to zero
package flash_seq_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int SYS_PERIOD_NS = 25;
    localparam int PROG_TIME_NS = 600000;
    localparam int ERASE_TIME_NS = 50000000;
    localparam int RESET_TIME_NS = 30000;
    localparam int PROG_CYCLES =
        (PROG_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int ERASE_CYCLES =
        (ERASE_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam logic [31:0] RESET_CYCLES = 32'((RESET_TIME_NS
        + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);

    // ---------------------------------------------------------------
    // opcodes
    // ---------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_SEC_ERASE = 8'h44;
    localparam logic [7:0] OP_SEC_PROG = 8'h42;
    localparam logic [7:0] OP_SEC_READ = 8'h48;
    localparam logic [7:0] OP_PARAM_READ = 8'h5A;
    localparam logic [7:0] OP_RESET_ARM = 8'h66;
    localparam logic [7:0] OP_RESET_GO = 8'h99;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_QUAD_PROG = 8'h32;

    // ---------------------------------------------------------------
    // frame positions, counted in serial clock edges
    // ---------------------------------------------------------------
    localparam logic [15:0] OPCODE_EDGES = 16'h0008;
    localparam logic [15:0] HEADER_EDGES = 16'h0020;
    localparam logic [15:0] READ_START_EDGES = 16'h0028;
    localparam logic [15:0] QUAD_FIRST_EDGES = 16'h0022;
    localparam logic [15:0] EDGE_LIMIT = 16'hFFFF;

    // ---------------------------------------------------------------
    // secure region address fields and content
    // ---------------------------------------------------------------
    localparam logic [3:0] REGION_FIRST = 4'h1;
    localparam logic [3:0] REGION_LAST = 4'h3;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] LAST_OFFSET = 8'hFF;
    localparam logic [6:0] TOP_BLOCK_END = 7'h7F;

    typedef enum logic [1:0] {
        ST_IDLE, ST_WALK, ST_WAIT, ST_RECOVER
    } state_t;

    typedef enum logic [1:0] {
        JOB_MAIN, JOB_SEC_PROG, JOB_SEC_ERASE
    } job_t;

    typedef struct packed {
        logic en;
        logic [23:0] addr;
        logic [7:0] data;
    } arrayWrite_t;

endpackage

/* flash_cmd_sequencer.sv */
// Purpose: program, secure region and reset command handling
// Assumes: serial clock stops while select is high; select stays
//          high at least four system clocks between frames
// Notes: link words stand still after a frame, read once
//        the synchronised select rises
`timescale 1ns/1ps
`default_nettype none

module flash_cmd_sequencer #(
    parameter int PROG_CYCLES = flash_seq_pkg::PROG_CYCLES,
    parameter int ERASE_CYCLES = flash_seq_pkg::ERASE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic serialClk,
    input wire logic chipSelectN,
    input wire logic [3:0] dataLineIn,
    input wire logic fourLineEnableBit,
    input wire logic [4:0] blockProtectBits,
    input wire logic secureRegionLockBit,
    input wire logic [2:0] perRegionLockBits,
    output logic writeInProgressFlag,
    output logic writeEnableLatch,
    output logic resetRecovering,
    output logic softResetPulse,
    output flash_seq_pkg::arrayWrite_t arrayWrite,
    output logic dataLine1Out,
    output logic dataLine1Oe
);

    // ---------------------------------------------------------------
    // shared helpers
    // ---------------------------------------------------------------

    // region decode: zero fields, region 1..3
    function automatic logic regionValid(input logic [23:0] a);
        return a[23:16] == 8'h00 && a[11:8] == 4'h0 &&
            a[15:12] >= flash_seq_pkg::REGION_FIRST &&
            a[15:12] <= flash_seq_pkg::REGION_LAST;
    endfunction

    // protection: bp[2:0] sizes a span of 64K blocks,
    // bp[3] puts it at the bottom
    function automatic logic pageLocked(input logic [4:0] bp,
                                        input logic [23:0] a);
        logic [7:0] span;
        logic [7:0] blk;
        span = 8'h00;
        blk = {1'b0, a[22:16]};
        if (bp[2:0] != 3'h0) begin
            span = 8'h01 << (bp[2:0] - 3'h1);
        end
        if (bp[3]) begin
            return blk < span;
        end
        return blk > ({1'b0, flash_seq_pkg::TOP_BLOCK_END} - span);
    endfunction

    // parameter table: signature, two version bytes, then erased
    function automatic logic [7:0] paramByte(input logic [23:0] a);
        if (a[23:8] != 16'h0000) begin
            return flash_seq_pkg::ERASED_BYTE;
        end
        case (a[7:0])
            8'h00: return 8'h53;
            8'h01: return 8'h46;
            8'h02: return 8'h44;
            8'h03: return 8'h50;
            8'h04: return 8'h06;
            8'h05: return 8'h01;
            default: return flash_seq_pkg::ERASED_BYTE;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // storage shared across the two domains
    // ---------------------------------------------------------------
    logic [7:0] secMem_q [3][256];
    logic [7:0] pageBuf_q [256];
    logic [255:0] byteMask_q;
    logic [7:0] opcode_q;
    logic [23:0] addr_q;
    logic [15:0] edges_q;
    flash_seq_pkg::state_t state_q;
    logic wipLinkMeta_q;
    logic wipLink_q;

    // ---------------------------------------------------------------
    // link domain: frame capture on the serial clock
    // ---------------------------------------------------------------
    logic frameOpen_q;
    logic [15:0] prior;
    logic [15:0] rel;
    logic [7:0] shift_q;
    logic quadMode;
    logic dataPhase;
    logic byteDone;
    logic [7:0] newByte;
    logic [7:0] byteNum;
    logic [7:0] slot;
    logic progOpcode;
    logic writeOk;

    // select clears it, no edge needed after a frame
    always_ff @(posedge serialClk or posedge chipSelectN) begin
        if (chipSelectN) begin
            frameOpen_q <= 1'b0;
        end else begin
            frameOpen_q <= 1'b1;
        end
    end

    // edges before this one; zero on a frame's first edge
    assign prior = frameOpen_q ? edges_q : 16'h0000;
    assign rel = prior - flash_seq_pkg::HEADER_EDGES;
    assign quadMode = opcode_q == flash_seq_pkg::OP_QUAD_PROG;
    assign dataPhase = prior >= flash_seq_pkg::HEADER_EDGES;
    assign byteDone = dataPhase &&
        (quadMode ? rel[0] : rel[2:0] == 3'h7);
    assign newByte = quadMode ? {shift_q[3:0], dataLineIn}
                              : {shift_q[6:0], dataLineIn[0]};
    assign byteNum = quadMode ? rel[8:1] : rel[10:3];
    assign slot = addr_q[7:0] + byteNum;
    assign progOpcode = opcode_q == flash_seq_pkg::OP_PAGE_PROG ||
        quadMode || opcode_q == flash_seq_pkg::OP_SEC_PROG;
    // busy device keeps its buffer for the cycle
    assign writeOk = byteDone && progOpcode && !wipLink_q;

    // saturates rather than wrap on long frames
    always_ff @(posedge serialClk) begin
        if (prior != flash_seq_pkg::EDGE_LIMIT) begin
            edges_q <= prior + 16'h0001;
        end else begin
            edges_q <= prior;
        end
    end

    // opcode then address, single line, msb first
    always_ff @(posedge serialClk) begin
        if (prior < flash_seq_pkg::OPCODE_EDGES) begin
            opcode_q <= {opcode_q[6:0], dataLineIn[0]};
        end else if (!dataPhase) begin
            addr_q <= {addr_q[22:0], dataLineIn[0]};
        end
    end

    // data byte assembly
    always_ff @(posedge serialClk) begin
        shift_q <= newByte;
    end

    // later bytes overwrite earlier ones
    always_ff @(posedge serialClk) begin
        if (writeOk) begin
            pageBuf_q[slot] <= newByte;
        end
    end

    // cleared on the first data byte, so a status frame during
    // the walk cannot wipe the mask in use
    always_ff @(posedge serialClk) begin
        if (writeOk) begin
            if (rel < (quadMode ? 16'h0002 : 16'h0008)) begin
                byteMask_q <= '0;
            end
            byteMask_q[slot] <= 1'b1;
        end
    end

    // busy level into the link domain
    always_ff @(posedge serialClk) begin
        wipLinkMeta_q <= writeInProgressFlag;
        wipLink_q <= wipLinkMeta_q;
    end

    // ---------------------------------------------------------------
    // link domain: read data out on the falling edge
    // ---------------------------------------------------------------
    logic [15:0] readRel;
    logic [7:0] rdOffset;
    logic [7:0] rdByte;
    logic readActive;

    assign readRel = edges_q - flash_seq_pkg::READ_START_EDGES;
    assign rdOffset = addr_q[7:0] + readRel[10:3];
    assign readActive = frameOpen_q && !wipLink_q &&
        edges_q >= flash_seq_pkg::READ_START_EDGES &&
        (opcode_q == flash_seq_pkg::OP_SEC_READ ||
         opcode_q == flash_seq_pkg::OP_PARAM_READ);

    // regions change only while busy, when reads are off
    always_comb begin
        rdByte = flash_seq_pkg::ERASED_BYTE;
        if (opcode_q == flash_seq_pkg::OP_PARAM_READ) begin
            rdByte = paramByte({addr_q[23:8], rdOffset});
        end else if (regionValid(addr_q)) begin
            rdByte = secMem_q[addr_q[13:12] - 2'h1][rdOffset];
        end
    end

    // drive one bit per falling edge, msb first
    always_ff @(negedge serialClk or posedge chipSelectN) begin
        if (chipSelectN) begin
            dataLine1Oe <= 1'b0;
            dataLine1Out <= 1'b0;
        end else begin
            dataLine1Oe <= readActive;
            dataLine1Out <= rdByte[3'h7 - readRel[2:0]];
        end
    end

    // ---------------------------------------------------------------
    // system domain: frame end detection
    // ---------------------------------------------------------------
    logic csMeta_q;
    logic csSync_q;
    logic csLast_q;
    logic openMeta_q;
    logic openSync_q;
    logic sawClock_q;
    logic frameEnd;
    logic valid;

    // select and frame-open levels, two flops each
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            csMeta_q <= 1'b1;
            csSync_q <= 1'b1;
            csLast_q <= 1'b1;
            openMeta_q <= 1'b0;
            openSync_q <= 1'b0;
        end else begin
            csMeta_q <= chipSelectN;
            csSync_q <= csMeta_q;
            csLast_q <= csSync_q;
            openMeta_q <= frameOpen_q;
            openSync_q <= openMeta_q;
        end
    end

    assign frameEnd = csSync_q && !csLast_q;

    // a select pulse without clocks must not replay old words
    always_ff @(posedge sys_clk) begin
        if (rst || frameEnd) begin
            sawClock_q <= 1'b0;
        end else if (openSync_q) begin
            sawClock_q <= 1'b1;
        end
    end

    assign valid = frameEnd && sawClock_q;

    // ---------------------------------------------------------------
    // system domain: command decode at frame end
    // ---------------------------------------------------------------
    logic onlyOpcode;
    logic singleAligned;
    logic quadAligned;
    logic resetGo;
    logic armed_q;
    logic startJob;
    flash_seq_pkg::job_t jobKind;
    logic [1:0] regionIdx;

    assign onlyOpcode = edges_q == flash_seq_pkg::OPCODE_EDGES;
    // select rising mid-byte or before any data discards the frame
    assign singleAligned = edges_q[2:0] == 3'h0 &&
        edges_q >= flash_seq_pkg::READ_START_EDGES;
    assign quadAligned = !edges_q[0] &&
        edges_q >= flash_seq_pkg::QUAD_FIRST_EDGES;
    assign regionIdx = addr_q[13:12] - 2'h1;
    assign resetGo = valid && armed_q && onlyOpcode &&
        state_q != flash_seq_pkg::ST_RECOVER &&
        opcode_q == flash_seq_pkg::OP_RESET_GO;

    // program and erase only from idle with the latch set
    always_comb begin
        startJob = 1'b0;
        jobKind = flash_seq_pkg::JOB_MAIN;
        if (valid && state_q == flash_seq_pkg::ST_IDLE &&
                writeEnableLatch) begin
            unique case (opcode_q)
                flash_seq_pkg::OP_SEC_ERASE: begin
                    startJob = onlyOpcode &&
                        !secureRegionLockBit;
                    jobKind = flash_seq_pkg::JOB_SEC_ERASE;
                end
                flash_seq_pkg::OP_SEC_PROG: begin
                    startJob = singleAligned &&
                        regionValid(addr_q) &&
                        !perRegionLockBits[regionIdx];
                    jobKind = flash_seq_pkg::JOB_SEC_PROG;
                end
                flash_seq_pkg::OP_PAGE_PROG: begin
                    startJob = singleAligned &&
                        !pageLocked(blockProtectBits, addr_q);
                end
                flash_seq_pkg::OP_QUAD_PROG: begin
                    startJob = quadAligned &&
                        fourLineEnableBit &&
                        !pageLocked(blockProtectBits, addr_q);
                end
                default: begin
                    startJob = 1'b0;
                end
            endcase
        end
    end

    // any frame but 99h after 66h disarms
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            armed_q <= 1'b0;
        end else if (valid &&
                state_q != flash_seq_pkg::ST_RECOVER) begin
            armed_q <= onlyOpcode &&
                opcode_q == flash_seq_pkg::OP_RESET_ARM;
        end
    end

    // latch, cleared as a cycle starts
    always_ff @(posedge sys_clk) begin
        if (rst || resetGo) begin
            writeEnableLatch <= 1'b0;
        end else if (startJob) begin
            writeEnableLatch <= 1'b0;
        end else if (valid && onlyOpcode &&
                state_q == flash_seq_pkg::ST_IDLE) begin
            if (opcode_q == flash_seq_pkg::OP_WRITE_ENABLE) begin
                writeEnableLatch <= 1'b1;
            end else if (opcode_q ==
                    flash_seq_pkg::OP_WRITE_DISABLE) begin
                writeEnableLatch <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // system domain: self-timed cycle
    // ---------------------------------------------------------------
    logic [31:0] timer_q;
    logic [7:0] walkIdx_q;
    flash_seq_pkg::job_t job_q;
    logic [15:0] page_q;
    logic [1:0] region_q;

    // timer runs from start; walk takes its first 256 cycles
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= flash_seq_pkg::ST_IDLE;
            timer_q <= 32'h0000_0000;
            walkIdx_q <= 8'h00;
        end else if (resetGo) begin
            state_q <= flash_seq_pkg::ST_RECOVER;
            timer_q <= flash_seq_pkg::RESET_CYCLES;
            walkIdx_q <= 8'h00;
        end else begin
            unique case (state_q)
                flash_seq_pkg::ST_IDLE: begin
                    if (startJob) begin
                        state_q <= flash_seq_pkg::ST_WALK;
                        walkIdx_q <= 8'h00;
                        timer_q <= (jobKind ==
                            flash_seq_pkg::JOB_SEC_ERASE) ?
                            32'(ERASE_CYCLES) :
                            32'(PROG_CYCLES);
                    end
                end
                flash_seq_pkg::ST_WALK: begin
                    timer_q <= timer_q - 32'h0000_0001;
                    walkIdx_q <= walkIdx_q + 8'h01;
                    if (walkIdx_q == flash_seq_pkg::LAST_OFFSET) begin
                        state_q <= flash_seq_pkg::ST_WAIT;
                    end
                end
                flash_seq_pkg::ST_WAIT,
                flash_seq_pkg::ST_RECOVER: begin
                    timer_q <= timer_q - 32'h0000_0001;
                    if (timer_q == 32'h0000_0001) begin
                        state_q <= flash_seq_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // target of the cycle, held for the walk
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            job_q <= flash_seq_pkg::JOB_MAIN;
            page_q <= 16'h0000;
            region_q <= 2'h0;
        end else if (startJob) begin
            job_q <= jobKind;
            page_q <= addr_q[23:8];
            region_q <= regionIdx;
        end
    end

    // main array write stream, one slot per cycle
    always_ff @(posedge sys_clk) begin
        if (rst || resetGo) begin
            arrayWrite <= '0;
        end else begin
            arrayWrite.en <= state_q == flash_seq_pkg::ST_WALK &&
                job_q == flash_seq_pkg::JOB_MAIN &&
                byteMask_q[walkIdx_q];
            arrayWrite.addr <= {page_q, walkIdx_q};
            arrayWrite.data <= pageBuf_q[walkIdx_q];
        end
    end

    // programming only clears bits, erase sets all bits of unlocked regions
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int r = 0; r < 3; r++) begin
                for (int b = 0; b < 256; b++) begin
                    secMem_q[r][b] <= flash_seq_pkg::ERASED_BYTE;
                end
            end
        end else if (state_q == flash_seq_pkg::ST_WALK && !resetGo) begin
            if (job_q == flash_seq_pkg::JOB_SEC_PROG &&
                    byteMask_q[walkIdx_q]) begin
                secMem_q[region_q][walkIdx_q] <=
                    secMem_q[region_q][walkIdx_q] &
                    pageBuf_q[walkIdx_q];
            end else if (job_q == flash_seq_pkg::JOB_SEC_ERASE) begin
                for (int r = 0; r < 3; r++) begin
                    if (!perRegionLockBits[r]) begin
                        secMem_q[r][walkIdx_q] <=
                            flash_seq_pkg::ERASED_BYTE;
                    end
                end
            end
        end
    end

    // tells the rest of the device to drop volatile settings
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            softResetPulse <= 1'b0;
        end else begin
            softResetPulse <= resetGo;
        end
    end

    // status levels
    assign writeInProgressFlag = state_q == flash_seq_pkg::ST_WALK ||
        state_q == flash_seq_pkg::ST_WAIT;
    assign resetRecovering = state_q == flash_seq_pkg::ST_RECOVER;

endmodule // flash_cmd_sequencer

`default_nettype wire

/* flash_seq_assertions.sv */
// Purpose: timing checks on the flash command sequencer ports
// Assumes: everything sampled on sys_clk
// Notes: counters time the busy windows
`timescale 1ns/1ps
`default_nettype none
module flash_seq_assertions #(
    parameter int PROG_CYCLES = 300,
    parameter int ERASE_CYCLES = 300
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic chipSelectN,
    input wire logic writeInProgressFlag,
    input wire logic writeEnableLatch,
    input wire logic resetRecovering,
    input wire logic softResetPulse,
    input wire flash_seq_pkg::arrayWrite_t arrayWrite,
    input wire logic dataLine1Oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [31:0] wipCnt_q;
    logic [31:0] recCnt_q;
    // busy length
    always_ff @(posedge sys_clk) begin
        if (rst || !writeInProgressFlag) wipCnt_q <= 32'h0;
        else wipCnt_q <= wipCnt_q + 32'h1;
    end
    // recovery length
    always_ff @(posedge sys_clk) begin
        if (rst || !resetRecovering) recCnt_q <= 32'h0;
        else recCnt_q <= recCnt_q + 32'h1;
    end
    wip_clears_wel_a: assert property (
        $rose(writeInProgressFlag) |-> !writeEnableLatch)
        else $error("latch set at start");
    wip_length_a: assert property (
        $fell(writeInProgressFlag) |-> wipCnt_q == 32'(PROG_CYCLES)
        || wipCnt_q == 32'(ERASE_CYCLES) || resetRecovering)
        else $error("bad busy length");
    write_in_cycle_a: assert property (
        arrayWrite.en |-> writeInProgressFlag)
        else $error("write while idle");
    write_same_page_a: assert property (
        arrayWrite.en && $past(arrayWrite.en)
        |-> arrayWrite.addr[23:8] == $past(arrayWrite.addr[23:8]))
        else $error("write left its page");
    busy_no_latch_a: assert property (
        $rose(writeEnableLatch) |-> !writeInProgressFlag && !resetRecovering)
        else $error("latch set while busy");
    reset_pulse_once_a: assert property (
        softResetPulse |=> !softResetPulse)
        else $error("reset pulse too long");
    reset_clears_a: assert property (
        softResetPulse |-> resetRecovering && !writeEnableLatch
        && !writeInProgressFlag)
        else $error("reset left state behind");
    recover_length_a: assert property (
        $fell(resetRecovering) |-> recCnt_q == flash_seq_pkg::RESET_CYCLES)
        else $error("recovery has wrong length");
    idle_no_drive_a: assert property (
        chipSelectN [*2] |-> !dataLine1Oe)
        else $error("driven while deselected");
    cover property ($fell(writeInProgressFlag));
    cover property (softResetPulse);
    cover property (arrayWrite.en ##1 arrayWrite.en);
endmodule // flash_seq_assertions
bind flash_cmd_sequencer flash_seq_assertions #(.PROG_CYCLES(PROG_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)) chk_i (.sys_clk, .rst, .chipSelectN,
    .writeInProgressFlag, .writeEnableLatch, .resetRecovering,
    .softResetPulse, .arrayWrite, .dataLine1Oe);
`default_nettype wire

/* host_ctrl_model.sv */
// Purpose: host serial controller sending frames to the device
// Assumes: 64 ns serial clock, still outside frames
// Notes: idle lines toggle so a stale value is never seen
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model (
    output logic serialClk,
    output logic chipSelectN,
    output logic [3:0] dataLineIn
);
    initial begin
        serialClk = 1'b0;
        chipSelectN = 1'b1;
        dataLineIn = 4'hA;
    end
    // one bit time: data set before the rising edge
    task automatic beat(input logic [3:0] v);
        dataLineIn = v;
        #32 serialClk = 1'b1;
        #32 serialClk = 1'b0;
    endtask
    // bytes from index q on go four wide, msb nibble first
    task automatic frame(input logic [7:0] b[$], input int q);
        int i;
        int k;
        chipSelectN = 1'b0;
        for (i = 0; i < b.size(); i++) begin
            if (i >= q) for (k = 1; k >= 0; k--) beat(b[i][k*4+:4]);
            else for (k = 7; k >= 0; k--) beat({~dataLineIn[3:1], b[i][k]});
        end
        #32 chipSelectN = 1'b1;
        dataLineIn = ~dataLineIn;
    endtask
endmodule // host_ctrl_model
`default_nettype wire

/* tb.sv */
// Purpose: command sequences against the flash sequencer
// Assumes: short program and erase counts of 300 cycles
// Notes: array writes are collected into a sparse map
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk, rst, fourLineEnableBit, secureRegionLockBit;
    logic [4:0] blockProtectBits;
    logic [2:0] perRegionLockBits;
    logic serialClk, chipSelectN;
    logic [3:0] dataLineIn;
    logic writeInProgressFlag, writeEnableLatch, resetRecovering;
    flash_seq_pkg::arrayWrite_t arrayWrite;
    wire logic [1:0] st = {writeInProgressFlag, writeEnableLatch};
    int num_errors = 0;
    int cmp_count = 0;
    int nw = 0;
    logic [7:0] wmem [logic [23:0]];
    flash_cmd_sequencer #(.PROG_CYCLES(300), .ERASE_CYCLES(300)) DUT (
        .sys_clk, .rst, .serialClk, .chipSelectN, .dataLineIn,
        .fourLineEnableBit, .blockProtectBits, .secureRegionLockBit,
        .perRegionLockBits, .writeInProgressFlag, .writeEnableLatch,
        .resetRecovering, .softResetPulse(), .arrayWrite,
        .dataLine1Out(), .dataLine1Oe());
    host_ctrl_model hm (.serialClk, .chipSelectN, .dataLineIn);
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // record every programmed byte
    always @(posedge sys_clk) begin
        if (arrayWrite.en === 1'b1) begin
            wmem[arrayWrite.addr] = arrayWrite.data;
            nw++;
        end
    end
    task automatic conclude();
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // frame, then time for select to reach sys_clk
    task automatic cmd(input logic [7:0] b[$], input int q = 99);
        hm.frame(b, q);
        repeat (8) @(negedge sys_clk);
    endtask
    // bounded wait on busy or recovery
    task automatic waitfor(input bit rec, input logic exp);
        int n;
        for (n = 0; n < 1300; n++) begin
            if ((rec ? resetRecovering : writeInProgressFlag) === exp) break;
            @(negedge sys_clk);
        end
        if (n == 1300) begin
            num_errors++;
            conclude();
        end
    endtask
    initial begin
        rst = 1'b1;
        fourLineEnableBit = 1'b0;
        secureRegionLockBit = 1'b0;
        blockProtectBits = 5'h00;
        perRegionLockBits = 3'h0;
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk("idle", st, 0);
        cmd('{8'h06});
        cmd('{8'h02, 8'h00, 8'h12, 8'hFE, 8'hAA, 8'hBB, 8'hCC});
        chk("busy", st, 2);
        cmd('{8'h06});
        waitfor(0, 1'b0);
        chk("count", nw, 3);
        chk("wrap", {wmem[24'h0012FE], wmem[24'h001200]}, 16'hAACC);
        $display("page program test done");
        cmd('{8'h02, 8'h00, 8'h00, 8'h00, 8'h11});
        chk("no latch", st[1], 0);
        blockProtectBits = 5'h01;
        cmd('{8'h06});
        cmd('{8'h02, 8'h7F, 8'h00, 8'h00, 8'h55});
        chk("protect", st, 1);
        cmd('{8'h32, 8'h00, 8'h00, 8'h10, 8'h3C}, 4);
        chk("quad off", st[1], 0);
        fourLineEnableBit = 1'b1;
        cmd('{8'h32, 8'h00, 8'h00, 8'h10, 8'h3C}, 4);
        chk("quad on", st[1], 1);
        waitfor(0, 1'b0);
        chk("quad data", wmem[24'h000010], 8'h3C);
        $display("refusal test done");
        secureRegionLockBit = 1'b1;
        cmd('{8'h06});
        cmd('{8'h44});
        chk("locked erase", st[1], 0);
        secureRegionLockBit = 1'b0;
        cmd('{8'h44});
        chk("erase", st, 2);
        cmd('{8'h06});
        chk("busy refuse", writeEnableLatch, 0);
        waitfor(0, 1'b0);
        perRegionLockBits = 3'h1;
        cmd('{8'h06});
        cmd('{8'h42, 8'h00, 8'h10, 8'h00, 8'h77});
        chk("locked prog", st[1], 0);
        cmd('{8'h42, 8'h00, 8'h20, 8'h00, 8'h77});
        chk("secure prog", st[1], 1);
        waitfor(0, 1'b0);
        $display("secure region test done");
        cmd('{8'h66});
        cmd('{8'h06});
        cmd('{8'h99});
        chk("disarm", resetRecovering, 0);
        cmd('{8'h66});
        cmd('{8'h99});
        chk("reset", {resetRecovering, writeEnableLatch}, 2);
        cmd('{8'h06});
        chk("recovering", writeEnableLatch, 0);
        waitfor(1, 1'b0);
        cmd('{8'h06});
        chk("after recovery", writeEnableLatch, 1);
        $display("reset test done");
        conclude();
    end
endmodule // tb
`default_nettype wire
